// >>> inc/ltef_pkg.sv
// Constants, types and the code expansion shared by the threshold filter.
// Assumes one clock domain and a plain byte-wide register port.
// ----------------
// Contract
// - Ambient hysteresis widens both the low and the high ambient threshold.
// - Proximity hysteresis widens each of the three proximity thresholds.
// - Hysteresis is an 8-bit code expanding to 16 bits; 0x48 gives 24.
// - Ambient status changes after the masked count of consecutive samples.
// - Proximity status uses the same masking with its own persistence setting; 0x03 two, 0x07 three.
// - A compressed offset is added to every result except an overrange one; 0x60 gives 64.
// - All-ones result marks overrange only; the offset stage pulls other sums that land on it down to 0xFFFE.
// - Reset: ambient hysteresis 0x48, both persistence settings 0x03.
// ----------------
`default_nettype none
package ltef_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int VAL_W  = 16;
   localparam int KIND_W = 2;

   // ---------------
   // Register offsets
   // ---------------
   localparam logic [ADDR_W-1:0] OFS_AMB_HYST  = 8'h16;
   localparam logic [ADDR_W-1:0] OFS_PROX_HYST = 8'h17;
   localparam logic [ADDR_W-1:0] OFS_PROX_PERS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_AMB_PERS  = 8'h19;
   localparam logic [ADDR_W-1:0] OFS_MEAS_OFS  = 8'h1A;
   localparam logic [ADDR_W-1:0] OFS_EMIT_REC  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h21;

   // ---------------
   // Reset values
   // ---------------
   localparam logic [DATA_W-1:0] RST_AMB_HYST  = 8'h48;
   localparam logic [DATA_W-1:0] RST_PROX_HYST = 8'h48;
   localparam logic [DATA_W-1:0] RST_PERS      = 8'h03;
   localparam logic [DATA_W-1:0] RST_MEAS_OFS  = 8'h80;
   localparam logic [DATA_W-1:0] RST_ZERO      = 8'h00;

   // ---------------
   // Result codes and sample kinds
   // ---------------
   localparam logic [VAL_W-1:0]  OVERRANGE_CODE = 16'hFFFF;
   localparam logic [VAL_W-1:0]  TOP_VALID_CODE = 16'hFFFE;
   localparam logic [KIND_W-1:0] KIND_AMBIENT   = 2'h0;

   // Interrupt status bit positions.
   localparam int IRQ_AMB_LOW_BIT  = 0;
   localparam int IRQ_AMB_HIGH_BIT = 1;
   localparam int IRQ_PROX_BASE    = 2;

   // Compressed code layout: exponent high nibble, mantissa low nibble.
   localparam int EXP_HI   = 7;
   localparam int EXP_LO   = 4;
   localparam int MANT_HI  = 3;
   localparam int EXPAND_W = 20;

   typedef struct packed {
      logic [KIND_W-1:0] kind;
      logic              overrange;
      logic [VAL_W-1:0]  value;
   } ltef_sample_t;

   typedef struct packed {
      logic [KIND_W-1:0] kind;
      logic [VAL_W-1:0]  value;
   } ltef_result_t;

   // Expands a code to (1.mantissa << exponent) / 16; code zero gives zero.
   function automatic logic [VAL_W-1:0] ltef_expand(
         input logic [DATA_W-1:0] code);
      logic [EXPAND_W-1:0] wide;
      wide = {15'h0000, 1'b1, code[MANT_HI:0]} << code[EXP_HI:EXP_LO];
      if (code == RST_ZERO) begin
         return '0;
      end
      return wide[EXPAND_W-1:EXP_LO];
   endfunction

endpackage

`default_nettype wire

// >>> rtl/ltef_hyst_unit.sv
// One threshold comparator with hysteresis and a persistence filter.
// Assumes sample strobes and settings come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module ltef_hyst_unit #(
   parameter bit RISING = 1'b1
) (
   input  wire logic                         mclk_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         strobe_i,
   input  wire logic [ltef_pkg::VAL_W-1:0]   value_i,
   input  wire logic [ltef_pkg::VAL_W-1:0]   thr_i,
   input  wire logic [ltef_pkg::VAL_W-1:0]   hyst_i,
   input  wire logic [ltef_pkg::DATA_W-1:0]  pers_i,
   output logic                              status_o,
   output logic                              changed_o
);
   import ltef_pkg::*;

   typedef enum logic [1:0] {
      ST_CLEAR = 2'b01,
      ST_SET   = 2'b10
   } ltef_state_t;

   ltef_state_t         state;
   ltef_state_t         next_state;
   logic [DATA_W-1:0]   set_hist;
   logic [DATA_W-1:0]   clr_hist;
   logic [DATA_W-1:0]   next_set_hist;
   logic [DATA_W-1:0]   next_clr_hist;
   logic [VAL_W+1:0]    upper;
   logic [VAL_W+1:0]    lower;
   logic [VAL_W+1:0]    val_ext;
   logic                above;
   logic                below;
   logic                set_cond;
   logic                clr_cond;
   logic                set_ok;
   logic                clr_ok;

   // ---------------
   // Hysteresis band
   // ---------------
   // Signed extended arithmetic so a band that runs past zero never wraps.
   assign val_ext  = {2'b00, value_i};
   assign upper    = {2'b00, thr_i} + {2'b00, hyst_i};
   assign lower    = {2'b00, thr_i} - {2'b00, hyst_i};
   assign above    = $signed(val_ext) > $signed(upper);
   assign below    = $signed(val_ext) < $signed(lower);
   assign set_cond = RISING ? above : below;
   assign clr_cond = RISING ? below : above;

   // ---------------
   // Persistence history
   // ---------------
   assign next_set_hist = strobe_i ? {set_hist[DATA_W-2:0], set_cond}
                                   : set_hist;
   assign next_clr_hist = strobe_i ? {clr_hist[DATA_W-2:0], clr_cond}
                                   : clr_hist;
   assign set_ok = (next_set_hist & pers_i) == pers_i;
   assign clr_ok = (next_clr_hist & pers_i) == pers_i;

   always_comb begin
      case (state)
         ST_CLEAR: next_state = (strobe_i && set_ok) ? ST_SET : ST_CLEAR;
         ST_SET:   next_state = (strobe_i && clr_ok) ? ST_CLEAR : ST_SET;
         default:  next_state = ST_CLEAR;
      endcase
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state    <= ST_CLEAR;
         set_hist <= '0;
         clr_hist <= '0;
      end else begin
         state    <= next_state;
         set_hist <= next_set_hist;
         clr_hist <= next_clr_hist;
      end
   end

   assign status_o  = (state == ST_SET);
   assign changed_o = (state != next_state);

endmodule

`default_nettype wire

// >>> rtl/ltef_top.sv
// Post-processing of ambient and proximity results: offset, thresholds.
// Assumes samples arrive from the converter logic on the same clock and
// that the host reaches the parameters through the byte register port.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module ltef_top #(
   parameter int NUM_PROX = 3
) (
   input  wire logic                               mclk_i,
   input  wire logic                               sys_rst_i,
   input  wire logic [ltef_pkg::ADDR_W-1:0]        reg_addr_i,
   input  wire logic [ltef_pkg::DATA_W-1:0]        reg_wdata_i,
   input  wire logic                               reg_wr_i,
   input  wire logic                               reg_rd_i,
   output logic [ltef_pkg::DATA_W-1:0]             reg_rdata_o,
   input  wire logic                               sample_valid_i,
   input  wire ltef_pkg::ltef_sample_t             sample_i,
   input  wire logic [ltef_pkg::VAL_W-1:0]         amb_low_thr_i,
   input  wire logic [ltef_pkg::VAL_W-1:0]         amb_high_thr_i,
   input  wire logic [NUM_PROX-1:0][ltef_pkg::VAL_W-1:0] prox_thr_i,
   output logic                                    result_valid_o,
   output ltef_pkg::ltef_result_t                  result_o,
   output logic                                    amb_low_status_o,
   output logic                                    amb_high_status_o,
   output logic [NUM_PROX-1:0]                     prox_status_o,
   output logic                                    irq_o
);
   import ltef_pkg::*;

   localparam int NUM_UNITS = NUM_PROX + IRQ_PROX_BASE;

   // ------------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------------
   // Kinds 1 to 3 name the proximity channels, and all events share a byte.
   if (NUM_PROX < 1 || NUM_PROX > 3) begin : g_bad_prox
      $error("NUM_PROX must lie between 1 and 3.");
   end

   // ------------------------------------------------------------------------
   // Parameter registers
   // ------------------------------------------------------------------------
   logic [DATA_W-1:0]      ambient_hysteresis_param;
   logic [DATA_W-1:0]      proximity_hysteresis_param;
   logic [DATA_W-1:0]      proximity_persistence_param;
   logic [DATA_W-1:0]      ambient_persistence_param;
   logic [DATA_W-1:0]      measurement_offset_param;
   logic [DATA_W-1:0]      irq_status;
   logic [DATA_W-1:0]      irq_mask;
   logic [DATA_W-1:0]      next_irq_status;
   logic [DATA_W-1:0]      irq_events;
   logic [DATA_W-1:0]      rd_value;

   logic                   wr_amb_hyst;
   logic                   wr_prox_hyst;
   logic                   wr_prox_pers;
   logic                   wr_amb_pers;
   logic                   wr_meas_ofs;
   logic                   wr_irq_mask;
   logic                   rd_irq_stat;

   assign wr_amb_hyst  = reg_wr_i && (reg_addr_i == OFS_AMB_HYST);
   assign wr_prox_hyst = reg_wr_i && (reg_addr_i == OFS_PROX_HYST);
   assign wr_prox_pers = reg_wr_i && (reg_addr_i == OFS_PROX_PERS);
   assign wr_amb_pers  = reg_wr_i && (reg_addr_i == OFS_AMB_PERS);
   assign wr_meas_ofs  = reg_wr_i && (reg_addr_i == OFS_MEAS_OFS);
   assign wr_irq_mask  = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);
   assign rd_irq_stat  = reg_rd_i && (reg_addr_i == OFS_IRQ_STAT);

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ambient_hysteresis_param    <= RST_AMB_HYST;
         proximity_hysteresis_param  <= RST_PROX_HYST;
         proximity_persistence_param <= RST_PERS;
         ambient_persistence_param   <= RST_PERS;
         measurement_offset_param    <= RST_MEAS_OFS;
         irq_mask                    <= RST_ZERO;
      end else begin
         if (wr_amb_hyst) begin
            ambient_hysteresis_param <= reg_wdata_i;
         end
         if (wr_prox_hyst) begin
            proximity_hysteresis_param <= reg_wdata_i;
         end
         if (wr_prox_pers) begin
            proximity_persistence_param <= reg_wdata_i;
         end
         if (wr_amb_pers) begin
            ambient_persistence_param <= reg_wdata_i;
         end
         if (wr_meas_ofs) begin
            measurement_offset_param <= reg_wdata_i;
         end
         if (wr_irq_mask) begin
            irq_mask <= reg_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------------
   // The reserved emitter recovery byte and unmapped offsets read zero.
   always_comb begin
      case (reg_addr_i)
         OFS_AMB_HYST:  rd_value = ambient_hysteresis_param;
         OFS_PROX_HYST: rd_value = proximity_hysteresis_param;
         OFS_PROX_PERS: rd_value = proximity_persistence_param;
         OFS_AMB_PERS:  rd_value = ambient_persistence_param;
         OFS_MEAS_OFS:  rd_value = measurement_offset_param;
         OFS_EMIT_REC:  rd_value = RST_ZERO;
         OFS_IRQ_STAT:  rd_value = irq_status;
         OFS_IRQ_MASK:  rd_value = irq_mask;
         default:       rd_value = RST_ZERO;
      endcase
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= RST_ZERO;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_value : RST_ZERO;
      end
   end

   // ------------------------------------------------------------------------
   // Expanded settings
   // ------------------------------------------------------------------------
   logic [VAL_W-1:0]       amb_hyst_val;
   logic [VAL_W-1:0]       prox_hyst_val;
   logic [VAL_W-1:0]       offset_val;

   assign amb_hyst_val  = ltef_expand(ambient_hysteresis_param);
   assign prox_hyst_val = ltef_expand(proximity_hysteresis_param);
   assign offset_val    = ltef_expand(measurement_offset_param);

   // ---------------
   // Offset stage
   // ---------------
   // Sums wrap modulo 2^16; one landing on the overrange code is pulled
   // down by one, so only a real overrange shows all ones.
   logic [VAL_W-1:0]       sum_val;
   logic [VAL_W-1:0]       next_result_val;
   logic                   result_is_amb;

   assign sum_val = sample_i.value + offset_val;
   assign next_result_val = sample_i.overrange ? OVERRANGE_CODE
                          : (sum_val == OVERRANGE_CODE) ? TOP_VALID_CODE
                          : sum_val;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         result_valid_o <= 1'b0;
         result_o       <= '0;
      end else begin
         result_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            result_o.kind  <= sample_i.kind;
            result_o.value <= next_result_val;
         end
      end
   end

   assign result_is_amb = (result_o.kind == KIND_AMBIENT);

   // ---------------
   // Threshold units
   // ---------------
   // Unit 0 sets below the ambient low threshold, unit 1 above the high one.
   logic [NUM_UNITS-1:0]              unit_strobe;
   logic [NUM_UNITS-1:0]              unit_status;
   logic [NUM_UNITS-1:0]              unit_changed;
   logic [NUM_UNITS-1:0][VAL_W-1:0]   unit_thr;
   logic [NUM_UNITS-1:0][VAL_W-1:0]   unit_hyst;
   logic [NUM_UNITS-1:0][DATA_W-1:0]  unit_pers;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_UNITS; gi = gi + 1) begin : g_unit
         if (gi < IRQ_PROX_BASE) begin : g_amb
            assign unit_strobe[gi] = result_valid_o && result_is_amb;
            assign unit_thr[gi]    = (gi == IRQ_AMB_LOW_BIT) ? amb_low_thr_i
                                                             : amb_high_thr_i;
            assign unit_hyst[gi]   = amb_hyst_val;
            assign unit_pers[gi]   = ambient_persistence_param;
         end else begin : g_prox
            assign unit_strobe[gi] = result_valid_o &&
               (result_o.kind == KIND_W'(gi - IRQ_PROX_BASE + 1));
            assign unit_thr[gi]    = prox_thr_i[gi-IRQ_PROX_BASE];
            assign unit_hyst[gi]   = prox_hyst_val;
            assign unit_pers[gi]   = proximity_persistence_param;
         end

         ltef_hyst_unit #(
            .RISING    (gi != IRQ_AMB_LOW_BIT)
         ) u_unit (
            .mclk_i    (mclk_i),
            .sys_rst_i (sys_rst_i),
            .strobe_i  (unit_strobe[gi]),
            .value_i   (result_o.value),
            .thr_i     (unit_thr[gi]),
            .hyst_i    (unit_hyst[gi]),
            .pers_i    (unit_pers[gi]),
            .status_o  (unit_status[gi]),
            .changed_o (unit_changed[gi])
         );
      end
   endgenerate

   assign amb_low_status_o  = unit_status[IRQ_AMB_LOW_BIT];
   assign amb_high_status_o = unit_status[IRQ_AMB_HIGH_BIT];
   assign prox_status_o     = unit_status[NUM_UNITS-1:IRQ_PROX_BASE];

   // ------------------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------------------
   // A read clears what it returned; an event in the same cycle survives.
   assign irq_events      = DATA_W'(unit_changed);
   assign next_irq_status = (rd_irq_stat ? RST_ZERO : irq_status)
                          | irq_events;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_status <= RST_ZERO;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   assign irq_o = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// >>> verification/ltef_checker_props.sv
// Checker for the threshold filter: result timing, offset, status and irq.
// Assumes it is bound to ltef_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module ltef_checker #(
   parameter int NUM_PROX = 3
) (
   input wire logic                          mclk_i,
   input wire logic                          sys_rst_i,
   input wire logic [ltef_pkg::ADDR_W-1:0]   reg_addr_i,
   input wire logic [ltef_pkg::DATA_W-1:0]   reg_wdata_i,
   input wire logic                          reg_wr_i,
   input wire logic                          reg_rd_i,
   input wire logic [ltef_pkg::DATA_W-1:0]   reg_rdata_o,
   input wire logic                          sample_valid_i,
   input wire ltef_pkg::ltef_sample_t        sample_i,
   input wire logic                          result_valid_o,
   input wire ltef_pkg::ltef_result_t        result_o,
   input wire logic                          amb_low_status_o,
   input wire logic                          amb_high_status_o,
   input wire logic [NUM_PROX-1:0]           prox_status_o,
   input wire logic                          irq_o
);
   import ltef_pkg::*;

   logic [DATA_W-1:0] ofs_code;
   logic [DATA_W-1:0] amb_hyst;
   logic [DATA_W-1:0] irq_mask;
   logic [EXPAND_W:0] ofs_wide;
   logic [VAL_W-1:0]  ofs_val;
   logic [VAL_W-1:0]  sum_val;
   logic [VAL_W-1:0]  exp_val;

   // ---------------
   // Shadow settings.
   // ---------------
   assign ofs_wide = {16'h0000, 1'b1, ofs_code[3:0]} << ofs_code[7:4];
   assign ofs_val  = (ofs_code == 8'h00) ? 16'h0000 : ofs_wide[19:4];
   assign sum_val  = sample_i.value + ofs_val;
   assign exp_val  = (sum_val == 16'hFFFF) ? 16'hFFFE : sum_val;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ofs_code <= 8'h80;
         amb_hyst <= 8'h48;
         irq_mask <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == OFS_MEAS_OFS)
            ofs_code <= reg_wdata_i;
         if (reg_addr_i == OFS_AMB_HYST)
            amb_hyst <= reg_wdata_i;
         if (reg_addr_i == OFS_IRQ_MASK)
            irq_mask <= reg_wdata_i;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_take_plain;
      sample_valid_i && !sample_i.overrange;
   endsequence
   sequence s_take_over;
      sample_valid_i && sample_i.overrange;
   endsequence
   sequence s_amb_flip;
      $changed(amb_high_status_o) || $changed(amb_low_status_o);
   endsequence

   a_result_latency: assert property (
      sample_valid_i |=> result_valid_o) else $error("no result");
   a_no_stray_result: assert property (
      !sample_valid_i |=> !result_valid_o) else $error("stray result");
   a_offset_added: assert property (
      s_take_plain |=> result_o.value == $past(exp_val))
      else $error("offset wrong");
   a_overrange_kept: assert property (s_take_over |=>
      result_o.value == OVERRANGE_CODE &&
      result_o.kind == $past(sample_i.kind)) else $error("overrange lost");
   a_marker_reserved: assert property (s_take_plain |=>
      result_o.value != OVERRANGE_CODE) else $error("marker misused");
   a_amb_on_sample: assert property (s_amb_flip |->
      $past(sample_valid_i, 2) && $past(sample_i.kind, 2) == KIND_AMBIENT)
      else $error("stray ambient flip");
   a_prox_on_sample: assert property (
      $changed(prox_status_o) |->
      $past(sample_valid_i, 2) && $past(sample_i.kind, 2) != KIND_AMBIENT)
      else $error("stray proximity flip");
   a_irq_on_change: assert property ($changed(amb_high_status_o) &&
      irq_mask[IRQ_AMB_HIGH_BIT] |-> irq_o) else $error("missing interrupt");
   a_irq_masked: assert property (irq_mask == 8'h00 |-> !irq_o)
      else $error("masked interrupt");
   a_hyst_readback: assert property (reg_rd_i &&
      reg_addr_i == OFS_AMB_HYST |=> reg_rdata_o == $past(amb_hyst))
      else $error("hysteresis readback");
   a_rdata_quiet: assert property (
      !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray read data");
endmodule

bind ltef_top ltef_checker #(.NUM_PROX(NUM_PROX)) u_chk (.*);
`default_nettype wire

// >>> verification/ltef_host_model.sv
// Host side of the byte register port: one write or read per call.
// Assumes the filter answers reads one cycle later and never stalls.
`timescale 1ns/100ps
`default_nettype none

module ltef_host_model (
   input  wire logic                     mclk_i,
   output logic [ltef_pkg::ADDR_W-1:0]   reg_addr_o,
   output logic [ltef_pkg::DATA_W-1:0]   reg_wdata_o,
   output logic                          reg_wr_o,
   output logic                          reg_rd_o
);
   import ltef_pkg::*;

   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   // Released address and data show the inverse so stale values never match.
   task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                         input logic [DATA_W-1:0] data);
      @(posedge mclk_i);
      reg_addr_o  <= addr;
      reg_wdata_o <= data;
      reg_wr_o    <= wr;
      reg_rd_o    <= !wr;
      @(posedge mclk_i);
      reg_addr_o  <= ~addr;
      reg_wdata_o <= ~data;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the threshold filter, host model on the port.
// Assumes the checker file binds itself to the filter.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import ltef_pkg::*;

   logic              mclk_i;
   logic              sys_rst_i;
   logic [7:0]        reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_rdata;
   logic              sample_valid;
   ltef_sample_t      sample;
   logic [15:0]       amb_low_thr;
   logic [15:0]       amb_high_thr;
   logic [2:0][15:0]  prox_thr;
   logic              result_valid;
   ltef_result_t      result;
   logic              amb_low_st;
   logic              amb_high_st;
   logic [2:0]        prox_st;
   logic              irq;
   logic              rd_pend;
   logic [31:0]       lfsr;
   logic [7:0]        cur_ofs;
   logic [7:0]        rd_q[$];
   ltef_result_t      res_q[$];
   int                bad_count;
   int                checks;
   logic [7:0]        rst_addr [9] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
                                       8'h1C, 8'h20, 8'h21, 8'h30};
   logic [7:0]        rst_val [9] = '{8'h48, 8'h48, 8'h03, 8'h03, 8'h80,
                                      8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]        rw_addr [4] = '{8'h16, 8'h17, 8'h1A, 8'h21};
   logic [7:0]        ofs_code [5] = '{8'h00, 8'h48, 8'h60, 8'h70, 8'h80};
   logic [7:0]        pers_code [3] = '{8'h03, 8'h07, 8'hFF};
   int                pers_n [3] = '{2, 3, 8};

   ltef_host_model u_host (.mclk_i(mclk_i), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

   ltef_top #(.NUM_PROX(3)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .sample_valid_i(sample_valid), .sample_i(sample),
      .amb_low_thr_i(amb_low_thr), .amb_high_thr_i(amb_high_thr),
      .prox_thr_i(prox_thr), .result_valid_o(result_valid),
      .result_o(result), .amb_low_status_o(amb_low_st),
      .amb_high_status_o(amb_high_st), .prox_status_o(prox_st),
      .irq_o(irq));

   always #12.5 mclk_i = ~mclk_i;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   function automatic logic [15:0] expand(input logic [7:0] c);
      logic [20:0] w;
      w = {16'h0000, 1'b1, c[3:0]} << c[7:4];
      return (c == 8'h00) ? 16'h0000 : w[19:4];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      u_host.access(1'b0, a, 8'h00);
   endtask

   task automatic send(input logic [1:0] k, input logic ov,
                       input logic [15:0] v);
      ltef_result_t r;
      logic [15:0]  s;
      s = v + expand(cur_ofs);
      r.kind = k;
      r.value = ov ? 16'hFFFF : ((s == 16'hFFFF) ? 16'hFFFE : s);
      res_q.push_back(r);
      @(posedge mclk_i);
      sample_valid <= 1'b1;
      sample <= {k, ov, v};
   endtask

   // Ends a burst and waits until any status change has landed.
   task automatic burst(input logic [1:0] k, input logic [15:0] v,
                        input int n);
      for (int i = 0; i < n; i++) begin
         send(k, 1'b0, v);
      end
      @(posedge mclk_i);
      sample_valid <= 1'b0;
      sample.value <= ~sample.value;
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   always @(posedge mclk_i) rd_pend <= reg_rd;

   always @(negedge mclk_i) begin
      if (rd_pend === 1'b1) begin
         check(rd_q.size() > 0, 1'b1);
         check(reg_rdata, rd_q.pop_front());
      end
      if (result_valid === 1'b1) begin
         check(res_q.size() > 0, 1'b1);
         check(result, res_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      $display("MISMATCH %0t timeout", $time);
      results();
   end

   initial begin
      mclk_i = 1'b0;
      sys_rst_i = 1'b1;
      sample_valid = 1'b0;
      sample = '0;
      amb_low_thr = 16'h0000;
      amb_high_thr = 16'h7000;
      prox_thr = {3{16'h7000}};
      lfsr = 32'h629c;
      cur_ofs = 8'h80;
      bad_count = 0;
      checks = 0;
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_reg(rst_addr[i], rst_val[i]);
      end
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(rw_addr[i], lfsr[7:0]);
         rd_reg(rw_addr[i], lfsr[7:0]);
      end
      wr_reg(8'h1C, 8'hA5);
      rd_reg(8'h1C, 8'h00);
      wr_reg(8'h30, 8'h5A);
      rd_reg(8'h30, 8'h00);
      wr_reg(OFS_IRQ_STAT, 8'hFF);
      rd_reg(OFS_IRQ_STAT, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr_reg(OFS_MEAS_OFS, ofs_code[i]);
         cur_ofs = ofs_code[i];
         for (int j = 0; j < 4; j++) begin
            lfsr = lfsr_next(lfsr);
            send(KIND_AMBIENT, 1'b0, {4'h0, lfsr[11:0]});
         end
         burst(KIND_AMBIENT, 16'd0, 0);
      end
      send(2'h1, 1'b0, 16'hFEFF);
      send(2'h2, 1'b1, lfsr[15:0]);
      burst(2'h3, 16'd0, 0);
      wr_reg(OFS_MEAS_OFS, 8'h00);
      cur_ofs = 8'h00;
      wr_reg(OFS_AMB_HYST, 8'h48);
      wr_reg(OFS_IRQ_MASK, 8'h02);
      rd_reg(OFS_IRQ_STAT, 8'h00);
      amb_low_thr <= 16'd100;
      amb_high_thr <= 16'd1000;
      burst(KIND_AMBIENT, 16'd1024, 3);
      check(amb_high_st, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wr_reg(OFS_AMB_PERS, pers_code[i]);
         burst(KIND_AMBIENT, i[0] ? 16'd500 : 16'd1025, pers_n[i] - 1);
         check(amb_high_st, i[0]);
         burst(KIND_AMBIENT, i[0] ? 16'd500 : 16'd1025, 1);
         check(amb_high_st, !i[0]);
         check(irq, 1'b1);
         rd_reg(OFS_IRQ_STAT, 8'h02);
         @(negedge mclk_i);
         check(irq, 1'b0);
      end
      wr_reg(OFS_AMB_PERS, 8'h03);
      burst(KIND_AMBIENT, 16'd75, 2);
      check({amb_low_st, amb_high_st}, 2'b10);
      rd_reg(OFS_IRQ_STAT, 8'h03);
      wr_reg(OFS_PROX_HYST, 8'h48);
      wr_reg(OFS_PROX_PERS, 8'h07);
      wr_reg(OFS_IRQ_MASK, 8'h00);
      prox_thr <= {3{16'd500}};
      for (int c = 0; c < 3; c++) begin
         burst(2'(c + 1), 16'd524, 3);
         burst(2'(c + 1), 16'd525, 2);
         check(prox_st[c], 1'b0);
         burst(2'(c + 1), 16'd525, 1);
         check(prox_st[c], 1'b1);
      end
      check(irq, 1'b0);
      rd_reg(OFS_IRQ_STAT, 8'h1C);
      burst(2'h1, 16'd475, 3);
      check(prox_st, 3'b110);
      rd_reg(OFS_IRQ_STAT, 8'h04);
      repeat (4) @(posedge mclk_i);
      check(rd_q.size() + res_q.size(), 0);
      results();
   end
endmodule
`default_nettype wire
